/* hw/pfc_pkg.sv */
// Shared constants for the pixel fix control front end.
package pfc_pkg;
  // Register byte offsets on the register bus.
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SRST = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_SPAT = 12'h00c;
  localparam logic [11:0] OFS_TEMP = 12'h010;
  localparam logic [11:0] OFS_AGE = 12'h014;
  localparam logic [11:0] OFS_NCAND = 12'h018;
  localparam logic [11:0] OFS_LCAND = 12'h01c;
  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam int SRST_BIT = 0;
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_LOCK_BIT = 7;
  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] SRST_RESET = 32'h0000_0000;
  localparam logic [15:0] SPAT_DEF = 16'h0010;
  localparam logic [15:0] TEMP_DEF = 16'h0010;
  localparam logic [15:0] AGE_DEF = 16'h0100;
  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Video timing figures.
  localparam int LAT_EXTRA = 18;
  localparam logic [1:0] LOCK_FRAMES = 2'h2;
endpackage

/* hw/pfc_strm_if.sv */
// Valid and ready stream carrier between the front end and its output buffer.
`timescale 1ns/1ps
interface pfc_strm_if #(parameter int W = 11) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hw/pfc_skid.sv */
// Two-entry output buffer with valid and ready on both sides.
`timescale 1ns/1ps
module pfc_skid #(
  parameter int W = 11
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  pfc_strm_if.snk in_s,
  pfc_strm_if.src out_s
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
  } pfc_skid_type;

  pfc_skid_type r_reg;
  pfc_skid_type r_next;
  logic push;
  logic pop;

  // Ready depends only on the count, so no combinational loop through the source.
  assign in_s.ready = (r_reg.cnt != 2'h2);
  assign out_s.valid = (r_reg.cnt != 2'h0);
  assign out_s.data = r_reg.d0;
  assign push = en & in_s.valid & in_s.ready;
  assign pop = en & out_s.valid & out_s.ready;

  // Head entry drives the outputs; the second entry catches a word during a stall.
  always_comb begin
    r_next = r_reg;
    if (clr) begin
      r_next = '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (r_reg.cnt == 2'h0) begin
            r_next.d0 = in_s.data;
          end else begin
            r_next.d1 = in_s.data;
          end
          r_next.cnt = r_reg.cnt + 2'h1;
        end
        2'b01: begin
          r_next.d0 = r_reg.d1;
          r_next.cnt = r_reg.cnt - 2'h1;
        end
        2'b11: begin
          if (r_reg.cnt == 2'h1) begin
            r_next.d0 = in_s.data;
          end else begin
            r_next.d0 = r_reg.d1;
            r_next.d1 = in_s.data;
          end
        end
        default: begin
          r_next.cnt = r_reg.cnt;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  skid_count_a: assert property (r_reg.cnt != 2'h3)
    else $error("Output buffer count out of range.");
  skid_clear_a: assert property (clr |=> r_reg.cnt == 2'h0 && r_reg.d0 == '0)
    else $error("Output buffer not emptied by clear.");
endmodule

/* hw/pfc_regs_top.sv */
// Register front end and video path of the pixel fix core.
// Behaviour
// - Bus responses are only OKAY or slave error, never decode error.
// - Control bit 0 low blocks all video; it resets to one.
// - Soft reset bit 0 resets timing and returns thresholds to defaults.
// - While soft reset is set, video outputs are zero and thresholds sit at their defaults.
// - Every register reads back over the bus.
// - Threshold registers have shadow and working copies.
// - A threshold write updates the shadow copy at once.
// - Reading a threshold returns its shadow copy.
// - Vertical blanking rise copies shadows to working when bit 1 is one.
// - Clock enable low freezes the video path except synchronous clear and soft reset; the bus still works.
// - Synchronous clear zeroes the video outputs, timing and candidate count; thresholds and control registers keep their values.
// - One rising-edge clock, synchronous with the pixel clock.
// - Blanking and valid are delayed in phase with output pixels.
// - Pixel width is 8, 10 or 12, for input and output alike.
// - Column limit 32 to 4096 sizes counters and line buffers.
// - Row limit 32 to 4096 is range-checked only; no counter uses it.
// - Defective pixel limit sets the candidate memory depth.
// - Defective pixel limit is a power of two from 512 to 8192.
// - Status bit 0 empty, bit 1 full, bit 7 lock, rest reserved.
// - Video latency is two scan lines plus 18 cycles.
// - A 16-bit pixel age threshold counts frames before defect.
`timescale 1ns/1ps
module pfc_regs_top
  import pfc_pkg::*;
#(
  parameter int DATA_WIDTH = 8,
  parameter int MAX_COLS = 1023,
  parameter int MAX_ROWS = 1023,
  parameter int MAX_DP = 1024
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclr,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_WIDTH-1:0] video_data_in,
  input wire logic hblank_in,
  input wire logic vblank_in,
  input wire logic active_video_in,
  output logic [DATA_WIDTH-1:0] video_data_out,
  output logic hblank_out,
  output logic vblank_out,
  output logic active_video_out,
  output logic video_out_valid,
  input wire logic video_out_ready,
  output logic [7:0] core_status,
  output logic [31:0] num_candidates,
  output logic [15:0] thresh_spatial_work,
  output logic [DATA_WIDTH-1:0] thresh_temporal_work,
  output logic [15:0] thresh_age_work
);
  localparam int DW = DATA_WIDTH;
  localparam int PW = DW + 3;
  // Ring depth; the output buffer register adds the last cycle.
  localparam int DEPTH = 2 * MAX_COLS + LAT_EXTRA - 1;
  localparam int DPW = $clog2(DEPTH);
  localparam int CW = $clog2(MAX_COLS + 1);
  localparam int CPW = $clog2(MAX_DP);

  typedef struct packed {
    logic ctrl_en;
    logic ctrl_done;
    logic srst;
    logic [15:0] spat_sh;
    logic [DW-1:0] temp_sh;
    logic [15:0] age_sh;
    logic [15:0] spat_wk;
    logic [DW-1:0] temp_wk;
    logic [15:0] age_wk;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic vb_d;
    logic [1:0] frames;
    logic primed;
    logic [DPW-1:0] dptr;
    logic [CW-1:0] col;
    logic [DW-1:0] pix1;
    logic [DW-1:0] pix2;
    logic [CPW-1:0] cwr;
    logic [CPW:0] ccnt;
    logic [CPW:0] ncand;
  } pfc_state_type;

  pfc_state_type r_reg;
  pfc_state_type r_next;
  logic [PW-1:0] dmem [DEPTH];
  logic [CW-1:0] cmem [MAX_DP];
  logic wr_go;
  logic rd_go;
  logic adv;
  logic vb_rise;
  logic cand_we;
  logic cand_full;
  logic lock;
  logic [DW-1:0] diff;
  logic [31:0] rd_val;
  logic rd_ok;

  pfc_strm_if #(.W(PW)) in_if ();
  pfc_strm_if #(.W(PW)) out_if ();

  // Byte-lane merge of a write into the old register value.
  function automatic logic [31:0] pfc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Address and data are taken together, one write in flight at a time.
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~r_reg.bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~r_reg.rvalid;
  assign rd_go = s_axi_arvalid & ~r_reg.rvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rdata = r_reg.rdata;

  // The pipe advances only when enabled, out of reset and the buffer has room.
  assign adv = ce & ~sclr & r_reg.ctrl_en & ~r_reg.srst & in_if.ready;
  assign vb_rise = vblank_in & ~r_reg.vb_d;
  assign diff = (video_data_in > r_reg.pix2) ? video_data_in - r_reg.pix2
                                             : r_reg.pix2 - video_data_in;
  assign cand_full = (r_reg.ccnt == (CPW + 1)'(MAX_DP));
  // Same-colour neighbour two pixels back sets the outlier test.
  assign cand_we = adv & active_video_in & ~cand_full & (16'(diff) > r_reg.spat_wk);
  assign lock = (r_reg.frames == LOCK_FRAMES);

  // Stale ring contents are masked as zero until the ring has been filled once.
  assign in_if.valid = adv;
  assign in_if.data = r_reg.primed ? dmem[r_reg.dptr] : '0;
  assign out_if.ready = video_out_ready;

  // Outputs come from the buffer head register.
  assign video_data_out = out_if.data[DW-1:0];
  assign vblank_out = out_if.data[DW];
  assign hblank_out = out_if.data[DW+1];
  assign active_video_out = out_if.data[DW+2];
  assign video_out_valid = out_if.valid;
  assign core_status = {lock, 5'h00, cand_full, (r_reg.ccnt == '0)};
  assign num_candidates = 32'(r_reg.ncand);
  assign thresh_spatial_work = r_reg.spat_wk;
  assign thresh_temporal_work = r_reg.temp_wk;
  assign thresh_age_work = r_reg.age_wk;

  // Read decode; threshold reads see the shadow copies.
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    if (s_axi_araddr == OFS_CTRL) begin
      rd_val = 32'({r_reg.ctrl_done, r_reg.ctrl_en});
    end else if (s_axi_araddr == OFS_SRST) begin
      rd_val = 32'(r_reg.srst);
    end else if (s_axi_araddr == OFS_STAT) begin
      rd_val = 32'(core_status);
    end else if (s_axi_araddr == OFS_SPAT) begin
      rd_val = 32'(r_reg.spat_sh);
    end else if (s_axi_araddr == OFS_TEMP) begin
      rd_val = 32'(r_reg.temp_sh);
    end else if (s_axi_araddr == OFS_AGE) begin
      rd_val = 32'(r_reg.age_sh);
    end else if (s_axi_araddr == OFS_NCAND) begin
      rd_val = 32'(r_reg.ncand);
    end else if (s_axi_araddr == OFS_LCAND) begin
      rd_val = 32'(cmem[CPW'(r_reg.cwr - 1'b1)]);
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Next-state logic for bus registers, thresholds and video timing.
  always_comb begin
    logic [31:0] wv;
    wv = '0;
    r_next = r_reg;
    // The response stays up until the master takes it.
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      if (s_axi_awaddr == OFS_CTRL) begin
        wv = pfc_merge(32'({r_reg.ctrl_done, r_reg.ctrl_en}), s_axi_wdata, s_axi_wstrb);
        r_next.ctrl_en = wv[CTRL_EN_BIT];
        r_next.ctrl_done = wv[CTRL_DONE_BIT];
      end else if (s_axi_awaddr == OFS_SRST) begin
        wv = pfc_merge(32'(r_reg.srst), s_axi_wdata, s_axi_wstrb);
        r_next.srst = wv[SRST_BIT];
      end else if (s_axi_awaddr == OFS_SPAT) begin
        wv = pfc_merge(32'(r_reg.spat_sh), s_axi_wdata, s_axi_wstrb);
        r_next.spat_sh = wv[15:0];
      end else if (s_axi_awaddr == OFS_TEMP) begin
        wv = pfc_merge(32'(r_reg.temp_sh), s_axi_wdata, s_axi_wstrb);
        r_next.temp_sh = wv[DW-1:0];
      end else if (s_axi_awaddr == OFS_AGE) begin
        wv = pfc_merge(32'(r_reg.age_sh), s_axi_wdata, s_axi_wstrb);
        r_next.age_sh = wv[15:0];
      end else begin
        // Read-only and unmapped offsets refuse writes.
        r_next.bresp = RESP_SLVERR;
      end
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      r_next.rvalid = 1'b1;
      r_next.rdata = rd_val;
      r_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Clear and soft reset restart the timing; a frozen clock enable holds it all.
    if (sclr || r_reg.srst) begin
      r_next.vb_d = 1'b0;
      r_next.frames = '0;
      r_next.primed = 1'b0;
      r_next.dptr = '0;
      r_next.col = '0;
      r_next.pix1 = '0;
      r_next.pix2 = '0;
      r_next.cwr = '0;
      r_next.ccnt = '0;
      r_next.ncand = '0;
    end else if (ce) begin
      r_next.vb_d = vblank_in;
      if (adv) begin
        if (r_reg.dptr == DPW'(DEPTH - 1)) begin
          r_next.dptr = '0;
          r_next.primed = 1'b1;
        end else begin
          r_next.dptr = r_reg.dptr + 1'b1;
        end
        if (hblank_in) begin
          r_next.col = '0;
        end else if (active_video_in) begin
          r_next.col = r_reg.col + 1'b1;
          r_next.pix1 = video_data_in;
          r_next.pix2 = r_reg.pix1;
        end
        if (cand_we) begin
          r_next.cwr = r_reg.cwr + 1'b1;
          r_next.ccnt = r_reg.ccnt + 1'b1;
        end
      end
      // Frame boundary: count for lock, publish candidates, commit thresholds.
      if (vb_rise) begin
        if (!lock) begin
          r_next.frames = r_reg.frames + 2'h1;
        end
        r_next.ncand = r_reg.ccnt;
        r_next.ccnt = '0;
        r_next.cwr = '0;
        // Without the semaphore a half-written set would tear the image.
        if (r_reg.ctrl_done) begin
          r_next.spat_wk = r_reg.spat_sh;
          r_next.temp_wk = r_reg.temp_sh;
          r_next.age_wk = r_reg.age_sh;
        end
      end
    end
    if (r_reg.srst) begin
      r_next.spat_sh = SPAT_DEF;
      r_next.temp_sh = DW'(TEMP_DEF);
      r_next.age_sh = AGE_DEF;
      r_next.spat_wk = SPAT_DEF;
      r_next.temp_wk = DW'(TEMP_DEF);
      r_next.age_wk = AGE_DEF;
    end
  end

  // State register on the single rising-edge clock.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.ctrl_en <= CTRL_RESET[CTRL_EN_BIT];
      r_reg.ctrl_done <= CTRL_RESET[CTRL_DONE_BIT];
      r_reg.srst <= SRST_RESET[SRST_BIT];
      r_reg.spat_sh <= SPAT_DEF;
      r_reg.temp_sh <= DW'(TEMP_DEF);
      r_reg.age_sh <= AGE_DEF;
      r_reg.spat_wk <= SPAT_DEF;
      r_reg.temp_wk <= DW'(TEMP_DEF);
      r_reg.age_wk <= AGE_DEF;
    end else begin
      r_reg <= r_next;
    end
  end

  // Delay ring keeps blanking and valid beside their pixel; no reset is needed.
  always_ff @(posedge sys_clk) begin
    if (adv) begin
      dmem[r_reg.dptr] <= {active_video_in, hblank_in, vblank_in, video_data_in};
    end
    if (cand_we) begin
      cmem[r_reg.cwr] <= r_reg.col;
    end
  end

  // Output buffer; clear and soft reset zero its head at once.
  pfc_skid #(.W(PW)) u_skid (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(sclr | r_reg.srst),
    .en(ce),
    .in_s(in_if),
    .out_s(out_if)
  );

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence rd_spat_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_SPAT;
  endsequence
  sequence wr_spat_s;
    wr_go && s_axi_awaddr == OFS_SPAT && s_axi_wstrb == 4'hf && !r_reg.srst;
  endsequence

  param_cfg_a: assert property (DATA_WIDTH inside {8, 10, 12} && MAX_COLS >= 32 &&
    MAX_COLS <= 4096 && MAX_ROWS >= 32 && MAX_ROWS <= 4096 &&
    MAX_DP inside {512, 1024, 2048, 4096, 8192})
    else $error("Build parameters out of range.");
  no_decerr_a: assert property ((s_axi_bvalid |-> s_axi_bresp != RESP_DECERR) and
    (s_axi_rvalid |-> s_axi_rresp != RESP_DECERR))
    else $error("Decode error response issued.");
  disable_block_a: assert property (!r_reg.ctrl_en && !sclr && !r_reg.srst |->
    !in_if.valid ##1 $stable(r_reg.dptr) && $stable(r_reg.col))
    else $error("Video advanced while disabled.");
  srst_zero_a: assert property (r_reg.srst |=> video_data_out == '0 && !active_video_out &&
    !hblank_out && !vblank_out && r_reg.spat_wk == SPAT_DEF)
    else $error("Outputs not zero during soft reset.");
  shadow_write_a: assert property (wr_spat_s |=> r_reg.spat_sh == 16'($past(s_axi_wdata)))
    else $error("Shadow not updated by write.");
  read_shadow_a: assert property (rd_spat_s |=> s_axi_rvalid &&
    s_axi_rdata == 32'($past(r_reg.spat_sh)))
    else $error("Read did not return shadow value.");
  copy_vblank_a: assert property (ce && !sclr && !r_reg.srst && vb_rise && r_reg.ctrl_done
    |=> r_reg.age_wk == $past(r_reg.age_sh) && r_reg.spat_wk == $past(r_reg.spat_sh))
    else $error("Working copy missed at blanking.");
  ce_hold_a: assert property (!ce && !sclr && !r_reg.srst |=> $stable(video_data_out) &&
    $stable(active_video_out) && $stable(r_reg.dptr))
    else $error("State moved with clock enable low.");
  sclr_zero_a: assert property (sclr |=> video_data_out == '0 && !active_video_out &&
    !out_if.valid && r_reg.dptr == '0)
    else $error("Synchronous clear did not zero outputs.");
endmodule

/* test/pfc_host_model.sv */
// Register bus master model that issues single reads and writes.
`timescale 1ns/1ps
module pfc_host_model
  import pfc_pkg::*;
(
  input wire logic sys_clk,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int n_to = 0;
  // Cycles the master waits before it takes a response, set by the bench.
  int lag = 0;
  // Idle bus at time zero.
  initial begin
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
  end
  // Bounded wait for one handshake flag; a hang is counted, not endured.
  task automatic wt(input int k);
    int i;
    for (i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      if ((k == 0 && s_axi_awready) || (k == 1 && s_axi_bvalid) ||
          (k == 2 && s_axi_arready) || (k == 3 && s_axi_rvalid)) break;
    end
    if (i == 64) n_to++;
  endtask
  // Address and data go out together; released lines show inverted values.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    wt(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    repeat (lag) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    wt(1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read address, then collect data and response at the same edge.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wt(2);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (lag) @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    wt(3);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* test/pixel_fix_ctrl_regs_bench.sv */
// Self-checking bench for the pixel fix register front end.
`timescale 1ns/1ps
module pixel_fix_ctrl_regs_bench
  import pfc_pkg::*;
;
  localparam int RING = 2 * 32 + LAT_EXTRA - 1;
  logic sys_clk, rst, ce, sclr;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v1, v2, v3;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] video_data_in, video_data_out, core_status, thresh_temporal_work, cnt;
  logic hblank_in, vblank_in, active_video_in, hblank_out, vblank_out, active_video_out;
  logic video_out_valid, video_out_ready, en_m, sr_m, mon;
  logic [31:0] num_candidates;
  logic [15:0] thresh_spatial_work, thresh_age_work;
  logic [31:0] seed = 32'hb152fce3;
  logic [10:0] expq[$];
  int mismatches = 0;
  int n_checks = 0;

  pfc_regs_top #(.MAX_COLS(32)) dut (.sys_clk, .rst, .ce, .sclr, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .video_data_in, .hblank_in, .vblank_in, .active_video_in,
    .video_data_out, .hblank_out, .vblank_out, .active_video_out, .video_out_valid,
    .video_out_ready, .core_status, .num_candidates, .thresh_spatial_work,
    .thresh_temporal_work, .thresh_age_work);
  pfc_host_model host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Free-running clock at 4 ns.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rg_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    host.rd(a, d, r);
    chk("read data", e, d);
    chk("read resp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rg_wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    host.wr(a, v, r);
    chk("write resp", {30'h0, er}, {30'h0, r});
  endtask

  // A cleared path holds only zero words until the ring has filled once.
  task automatic seedq();
    expq.delete();
    repeat (RING) expq.push_back('0);
  endtask

  // Frames of 8 rows by 32 columns, last row blanked; the enable stalls at random.
  task automatic stream(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      d = xs();
      cnt <= cnt + 8'h1;
      ce <= d[9:8] != 2'h0;
      video_data_in <= d[7:0];
      hblank_in <= cnt[4:0] >= 5'd24;
      vblank_in <= cnt[7:5] == 3'd7;
      active_video_in <= cnt[4:0] < 5'd24 && cnt[7:5] != 3'd7;
    end
    @(posedge sys_clk);
    ce <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Every sampled word must leave in order, with its framing bits beside it.
  always @(posedge sys_clk) begin
    if (sclr) seedq();
    else if (mon && ce && en_m && !sr_m)
      expq.push_back({video_data_in, hblank_in, vblank_in, active_video_in});
    if (mon && ce && video_out_valid && video_out_ready) begin
      if (expq.size() == 0) chk("queue empty", 32'h0, 32'h1);
      else chk("video word", {21'h0, expq.pop_front()}, {21'h0, video_data_out,
        hblank_out, vblank_out, active_video_out});
    end
  end

  task automatic end_of_test();
    mismatches += host.n_to;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog against a hung run.
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    {rst, ce, sclr, video_data_in, hblank_in, vblank_in, active_video_in} = 14'h2000;
    {video_out_ready, en_m, sr_m, mon, cnt} = 12'hc00;
    seedq();
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rg_rd(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    rg_rd(OFS_SRST, SRST_RESET, RESP_OKAY);
    rg_rd(OFS_SPAT, {16'h0, SPAT_DEF}, RESP_OKAY);
    rg_rd(OFS_TEMP, {16'h0, TEMP_DEF}, RESP_OKAY);
    rg_rd(OFS_AGE, {16'h0, AGE_DEF}, RESP_OKAY);
    rg_rd(OFS_STAT, 32'h1, RESP_OKAY);
    rg_wr(OFS_STAT, 32'hffffffff, RESP_SLVERR);
    rg_wr(12'h100, xs(), RESP_SLVERR);
    rg_rd(12'h100, 32'h0, RESP_SLVERR);
    // Slow master updates thresholds with the done flag low.
    host.lag = 3;
    rg_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    v1 = xs() & 32'hffff;
    v2 = xs() & 32'hff;
    v3 = xs() & 32'hffff;
    rg_wr(OFS_SPAT, v1, RESP_OKAY);
    rg_wr(OFS_TEMP, v2, RESP_OKAY);
    rg_wr(OFS_AGE, v3, RESP_OKAY);
    rg_rd(OFS_SPAT, v1, RESP_OKAY);
    rg_rd(OFS_TEMP, v2, RESP_OKAY);
    rg_rd(OFS_AGE, v3, RESP_OKAY);
    host.lag = 0;
    mon <= 1'b1;
    stream(600);
    chk("spatial work", {16'h0, SPAT_DEF}, {16'h0, thresh_spatial_work});
    chk("age work", {16'h0, AGE_DEF}, {16'h0, thresh_age_work});
    rg_wr(OFS_CTRL, 32'h3, RESP_OKAY);
    stream(600);
    chk("spatial work", v1, {16'h0, thresh_spatial_work});
    chk("temporal work", v2, {24'h0, thresh_temporal_work});
    chk("age work", v3, {16'h0, thresh_age_work});
    chk("lock", 32'h1, {31'h0, core_status[STAT_LOCK_BIT]});
    // With the software enable off no input word enters the path.
    en_m = 1'b0;
    rg_wr(OFS_CTRL, 32'h2, RESP_OKAY);
    stream(300);
    rg_wr(OFS_CTRL, 32'h3, RESP_OKAY);
    en_m = 1'b1;
    stream(300);
    // A stalled sink: the head word stands while the buffer absorbs input.
    mon <= 1'b0;
    ce <= 1'b1;
    video_out_ready <= 1'b0;
    repeat (3) @(posedge sys_clk);
    v1 = {video_out_valid, video_data_out, hblank_out, vblank_out, active_video_out};
    repeat (8) @(posedge sys_clk);
    chk("stalled head", v1, {video_out_valid, video_data_out, hblank_out, vblank_out,
      active_video_out});
    sclr <= 1'b1;
    video_out_ready <= 1'b1;
    @(posedge sys_clk);
    // Enable drops with the clear so no word is sampled before the monitor restarts.
    sclr <= 1'b0;
    ce <= 1'b0;
    @(posedge sys_clk);
    chk("cleared", 32'h0, {video_out_valid, video_data_out, hblank_out, vblank_out,
      active_video_out});
    mon <= 1'b1;
    stream(300);
    // Soft reset forces defaults and silences the video side.
    sr_m = 1'b1;
    rg_wr(OFS_SRST, 32'h1, RESP_OKAY);
    // The buffer empties one edge after the soft reset bit is registered.
    @(posedge sys_clk);
    chk("soft reset out", 32'h0, {video_out_valid, video_data_out, hblank_out,
      vblank_out, active_video_out});
    rg_rd(OFS_STAT, 32'h1, RESP_OKAY);
    chk("candidates", 32'h0, num_candidates);
    rg_rd(OFS_SPAT, {16'h0, SPAT_DEF}, RESP_OKAY);
    chk("spatial work", {16'h0, SPAT_DEF}, {16'h0, thresh_spatial_work});
    rg_wr(OFS_SRST, 32'h0, RESP_OKAY);
    rg_rd(OFS_SRST, 32'h0, RESP_OKAY);
    sr_m = 1'b0;
    seedq();
    stream(300);
    end_of_test();
  end
endmodule
